// [hdl/mtseq_defs.vh]
// Register offsets, field positions, event codes and reset values of the trigger sequencer.
`ifndef MTSEQ_DEFS_VH
`define MTSEQ_DEFS_VH
`define MTSEQ_OFF_CTRL      8'h00
`define MTSEQ_OFF_RPT       8'h04
`define MTSEQ_OFF_TIMER     8'h08
`define MTSEQ_OFF_SWEEP     8'h0c
`define MTSEQ_OFF_DELAY     8'h10
`define MTSEQ_OFF_MCONF     8'h14
`define MTSEQ_OFF_STATUS    8'h18
`define MTSEQ_OFF_MASK      8'h1c
`define MTSEQ_OFF_STATE     8'h20
`define MTSEQ_CTRL_ARM_LSB  0
`define MTSEQ_CTRL_TRIG_LSB 3
`define MTSEQ_CTRL_SAMP_LSB 6
`define MTSEQ_CTRL_ACNT_LSB 16
`define MTSEQ_SEL_AUTO      3'h0
`define MTSEQ_SEL_EXT       3'h1
`define MTSEQ_SEL_HOLD      3'h2
`define MTSEQ_SEL_SINGLE    3'h3
`define MTSEQ_SEL_CREQ      3'h4
`define MTSEQ_SEL_TIMER     3'h5
`define MTSEQ_FUNC_DCV      3'h0
`define MTSEQ_FUNC_ACV      3'h1
`define MTSEQ_FUNC_ACDCV    3'h2
`define MTSEQ_FUNC_FREQ     3'h3
`define MTSEQ_FUNC_PER      3'h4
`define MTSEQ_METH_SYNC     2'h1
`define MTSEQ_METH_RNDM     2'h2
`define MTSEQ_ST_DONE       0
`define MTSEQ_ST_FAST       1
`define MTSEQ_ST_REJECT     2
`define MTSEQ_ST_START      3
`define MTSEQ_RST_RPT       16'h0001
`define MTSEQ_RST_TIMER     32'h0000_0001
`define MTSEQ_DELAY_AUTO    32'hffff_ffff
`define MTSEQ_ADLY_BASE     32'h0000_0040
`define MTSEQ_ADLY_RANGE    32'h0000_0010
`define MTSEQ_ADLY_RES      32'h0000_0020
`define MTSEQ_ADLY_ACBW     32'h0000_0100
`endif

// [hdl/mtseq_top.v]
// Measurement trigger sequencer with arm, trigger and sample events behind an APB slave.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mtseq_defs.vh"
// How it works
// - A sample event counts only after arm and trigger; one reading per sample event.
// - A consumed single-shot selection turns itself into hold.
// - One single-shot arm occurrence arms the sequencer the programmed repeat count of times; a count of zero arms once.
// - The repeat count applies only when the arm selection is single-shot.
// - Controller event needs empty output buffer, memory off or empty, and a data request.
// - As arm or trigger, repeated data requests within a group are one event.
// - As sample event, every separate data request that comes while a sample is awaited starts one reading.
// - The interval timer spaces readings of a group start to start.
// - An interval shorter than a reading raises trigger-too-fast.
// - Sweep loads interval and count; last written of sweep and count wins.
// - Timer or sweep pacing forces autorange off.
// - Timer or sweep pacing is rejected for AC sync/random, frequency and period.
// - The delay is inserted once, between trigger and first sample of a group.
// - Without a user delay the settling delay follows function, range, resolution, bandwidth.
// - A user delay stays until reset or rewrite; writing minus one restores automatic.
// - The delay register reads the delay now in effect.
// - The external event is a falling edge of the trigger input, usable at any level.
// - With automatic arming and an external trigger each further external edge starts a new group.
module mtseq_top
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext_trig,
  input  wire        data_req,
  input  wire        out_buf_empty,
  input  wire        mem_off_or_empty,
  input  wire        reading_done,
  output reg         reading_start,
  output reg         autorange_en,
  output reg         irq
);

  localparam [4:0] ST_ARM  = 5'h01;
  localparam [4:0] ST_TRIG = 5'h02;
  localparam [4:0] ST_DLY  = 5'h04;
  localparam [4:0] ST_SAMP = 5'h08;
  localparam [4:0] ST_READ = 5'h10;

  reg  [2:0]  arm_event_select;
  reg  [2:0]  trig_sel;
  reg  [2:0]  samp_sel;
  reg  [15:0] arm_count;
  reg  [15:0] readings_per_trigger;
  reg  [31:0] timer_iv;
  reg  [15:0] sweep_iv;
  reg  [15:0] sweep_n;
  reg         sweep_active;
  reg  [31:0] user_dly;
  reg         user_dly_on;
  reg  [2:0]  func;
  reg  [3:0]  range;
  reg  [3:0]  resol;
  reg         acbw;
  reg  [1:0]  acmeth;
  reg         autorange_req;
  reg  [3:0]  status;
  reg  [3:0]  mask;
  reg  [4:0]  state;
  reg  [15:0] arms_left;
  reg  [15:0] rdg_cnt;
  reg  [31:0] dly_cnt;
  reg  [31:0] tmr_cnt;
  reg         tmr_hit;
  reg         single_arm;
  reg         single_trig;
  reg         ext_s1;
  reg         ext_s2;
  reg         ext_s3;
  reg         creq_d;
  reg  [31:0] auto_dly;
  reg  [3:0]  next_status;
  reg  [3:0]  ev_set;
  reg  [31:0] rd_val;
  reg         rd_hit;

  wire        acc      = psel & penable & pready;
  wire        wr       = acc & pwrite;
  wire        ext_fall = ext_s3 & ~ext_s2;
  wire        creq_ok  = out_buf_empty & mem_off_or_empty & data_req;
  wire        creq_ev  = creq_ok & ~creq_d;
  wire        timed    = sweep_active | (samp_sel == `MTSEQ_SEL_TIMER);
  wire [15:0] n_rdg    = sweep_active ? sweep_n : readings_per_trigger;
  wire [31:0] iv       = sweep_active ? {16'h0000, sweep_iv} : timer_iv;
  wire [31:0] dly_now  = user_dly_on ? user_dly : auto_dly;
  wire        no_timer = ((func == `MTSEQ_FUNC_ACV) || (func == `MTSEQ_FUNC_ACDCV)) &&
                         ((acmeth == `MTSEQ_METH_SYNC) || (acmeth == `MTSEQ_METH_RNDM)) ||
                         (func == `MTSEQ_FUNC_FREQ) || (func == `MTSEQ_FUNC_PER);
  wire [7:0]  ctrl_samp_w = {5'h00, pwdata[`MTSEQ_CTRL_SAMP_LSB +: 3]};
  wire        rej_ctrl = wr && (paddr == `MTSEQ_OFF_CTRL) && no_timer &&
                         (ctrl_samp_w[2:0] == `MTSEQ_SEL_TIMER);
  wire        rej_swp  = wr && (paddr == `MTSEQ_OFF_SWEEP) && no_timer;

  // Event decode; every source is an argument so the wires follow it. Hold and timer never fire here.
  function ev_of;
    input [2:0] sel;
    input       single;
    input       ext;
    input       creq;
    begin
      case (sel)
        `MTSEQ_SEL_AUTO:   ev_of = 1'b1;
        `MTSEQ_SEL_EXT:    ev_of = ext;
        `MTSEQ_SEL_SINGLE: ev_of = single;
        `MTSEQ_SEL_CREQ:   ev_of = creq;
        default:           ev_of = 1'b0;
      endcase
    end
  endfunction

  wire arm_ev  = ev_of(arm_event_select, single_arm, ext_fall, creq_ev);
  wire trig_ev = ev_of(trig_sel, single_trig, ext_fall, creq_ev);
  wire samp_ev = timed ? (tmr_hit | (tmr_cnt == 32'h1)) : ev_of(samp_sel, 1'b0, ext_fall, creq_ev);

  // The first stage of the trigger synchroniser only feeds the second one.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
      creq_d <= 1'b0;
    end
    else
    begin
      ext_s1 <= ext_trig;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      creq_d <= creq_ok;
    end
  end

  // Settling delay is recomputed every cycle into a register, so a setting change shows up one clock later.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      auto_dly <= `MTSEQ_ADLY_BASE;
    else
      auto_dly <= `MTSEQ_ADLY_BASE * ({29'h0, func} + 32'h1) + `MTSEQ_ADLY_RANGE * {28'h0, range} +
                  `MTSEQ_ADLY_RES * {28'h0, resol} + (acbw ? `MTSEQ_ADLY_ACBW : 32'h0);
  end

  // Sequencer state machine.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state            <= ST_ARM;
      arms_left        <= 16'h0000;
      rdg_cnt          <= 16'h0000;
      dly_cnt          <= 32'h0;
      tmr_cnt          <= 32'h0;
      tmr_hit          <= 1'b0;
      reading_start    <= 1'b0;
      arm_event_select <= `MTSEQ_SEL_AUTO;
      trig_sel         <= `MTSEQ_SEL_AUTO;
      samp_sel         <= `MTSEQ_SEL_AUTO;
      arm_count        <= 16'h0001;
      single_arm       <= 1'b0;
      single_trig      <= 1'b0;
    end
    else
    begin
      reading_start <= 1'b0;
      if (tmr_cnt != 32'h0)
        tmr_cnt <= tmr_cnt - 32'h1;
      if (tmr_cnt == 32'h1)
        tmr_hit <= 1'b1;
      case (state)
        ST_ARM:
        begin
          if (arm_ev)
          begin
            if (arm_event_select == `MTSEQ_SEL_SINGLE)
            begin
              arms_left        <= (arm_count == 16'h0) ? 16'h1 : arm_count;
              single_arm       <= 1'b0;
              arm_event_select <= `MTSEQ_SEL_HOLD;
            end
            else
              arms_left <= 16'h0001;
            state <= ST_TRIG;
          end
        end
        ST_TRIG:
        begin
          if (trig_ev)
          begin
            if (trig_sel == `MTSEQ_SEL_SINGLE)
            begin
              single_trig <= 1'b0;
              trig_sel <= `MTSEQ_SEL_HOLD;
            end
            rdg_cnt <= 16'h0000;
            dly_cnt <= dly_now;
            tmr_hit <= 1'b0;
            state   <= ST_DLY;
          end
        end
        ST_DLY:
        begin
          if (dly_cnt == 32'h0)
          begin
            if (timed)
              tmr_hit <= 1'b1;
            state <= ST_SAMP;
          end
          else
            dly_cnt <= dly_cnt - 32'h1;
        end
        ST_SAMP:
        begin
          if (samp_ev)
          begin
            reading_start <= 1'b1;
            tmr_hit       <= 1'b0;
            tmr_cnt       <= (iv == 32'h0) ? 32'h1 : iv;
            state         <= ST_READ;
          end
        end
        ST_READ:
        begin
          if (reading_done)
          begin
            if (rdg_cnt + 16'h1 >= n_rdg)
            begin
              if (arms_left > 16'h1)
              begin
                arms_left <= arms_left - 16'h1;
                state     <= ST_TRIG;
              end
              else
              begin
                arms_left <= 16'h0000;
                state     <= ST_ARM;
              end
            end
            else
            begin
              rdg_cnt <= rdg_cnt + 16'h1;
              state   <= ST_SAMP;
            end
          end
        end
        default:
          state <= ST_ARM;
      endcase
      // A fresh command overrides the hardware switch to hold made in the same cycle.
      if (wr && (paddr == `MTSEQ_OFF_CTRL))
      begin
        arm_event_select <= pwdata[`MTSEQ_CTRL_ARM_LSB +: 3];
        trig_sel         <= pwdata[`MTSEQ_CTRL_TRIG_LSB +: 3];
        if (!rej_ctrl)
          samp_sel <= ctrl_samp_w[2:0];
        arm_count <= pwdata[`MTSEQ_CTRL_ACNT_LSB +: 16];
        single_arm  <= (pwdata[`MTSEQ_CTRL_ARM_LSB +: 3] == `MTSEQ_SEL_SINGLE);
        single_trig <= (pwdata[`MTSEQ_CTRL_TRIG_LSB +: 3] == `MTSEQ_SEL_SINGLE);
      end
    end
  end

  // Configuration registers written over the bus.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      readings_per_trigger <= `MTSEQ_RST_RPT;
      timer_iv             <= `MTSEQ_RST_TIMER;
      sweep_iv             <= 16'h0001;
      sweep_n              <= 16'h0001;
      sweep_active         <= 1'b0;
      user_dly             <= 32'h0;
      user_dly_on          <= 1'b0;
      func                 <= `MTSEQ_FUNC_DCV;
      range                <= 4'h0;
      resol                <= 4'h0;
      acbw                 <= 1'b0;
      acmeth               <= 2'h0;
      autorange_req        <= 1'b1;
      mask                 <= 4'h0;
    end
    else if (wr)
    begin
      case (paddr)
        `MTSEQ_OFF_RPT:
        begin
          readings_per_trigger <= pwdata[15:0];
          sweep_active         <= 1'b0;
        end
        `MTSEQ_OFF_TIMER:
          timer_iv <= pwdata;
        `MTSEQ_OFF_SWEEP:
        begin
          if (!rej_swp)
          begin
            sweep_iv     <= pwdata[31:16];
            sweep_n      <= pwdata[15:0];
            sweep_active <= 1'b1;
          end
        end
        `MTSEQ_OFF_DELAY:
        begin
          user_dly_on <= (pwdata != `MTSEQ_DELAY_AUTO);
          user_dly    <= pwdata;
        end
        `MTSEQ_OFF_MCONF:
        begin
          func          <= pwdata[2:0];
          acmeth        <= pwdata[5:4];
          range         <= pwdata[11:8];
          resol         <= pwdata[15:12];
          acbw          <= pwdata[16];
          autorange_req <= pwdata[17];
        end
        `MTSEQ_OFF_MASK:
          mask <= pwdata[3:0];
        default:
          mask <= mask;
      endcase
    end
  end

  // Sticky events: a set in the clearing cycle survives the write of one.
  always @*
  begin
    ev_set                   = 4'h0;
    ev_set[`MTSEQ_ST_DONE]   = (state == ST_READ) && reading_done && (rdg_cnt + 16'h1 >= n_rdg);
    ev_set[`MTSEQ_ST_FAST]   = (state == ST_READ) && timed && (tmr_cnt == 32'h1);
    ev_set[`MTSEQ_ST_REJECT] = rej_ctrl | rej_swp;
    ev_set[`MTSEQ_ST_START]  = reading_start;
    next_status              = status;
    if (wr && (paddr == `MTSEQ_OFF_STATUS))
      next_status = status & ~pwdata[3:0];
    next_status = next_status | ev_set;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status       <= 4'h0;
      irq          <= 1'b0;
      autorange_en <= 1'b0;
    end
    else
    begin
      status       <= next_status;
      irq          <= |(next_status & mask);
      autorange_en <= autorange_req & ~timed;
    end
  end

  // Read mux; unmapped addresses answer with an error and zero data.
  always @*
  begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case (paddr)
      `MTSEQ_OFF_CTRL:   rd_val = {arm_count, 7'h00, samp_sel, trig_sel, arm_event_select};
      `MTSEQ_OFF_RPT:    rd_val = {16'h0000, readings_per_trigger};
      `MTSEQ_OFF_TIMER:  rd_val = timer_iv;
      `MTSEQ_OFF_SWEEP:  rd_val = {sweep_iv, sweep_n};
      `MTSEQ_OFF_DELAY:  rd_val = dly_now;
      `MTSEQ_OFF_MCONF:  rd_val = {14'h0, autorange_req, acbw, resol, range, 2'h0, acmeth, 1'b0, func};
      `MTSEQ_OFF_STATUS: rd_val = {28'h0, status};
      `MTSEQ_OFF_MASK:   rd_val = {28'h0, mask};
      `MTSEQ_OFF_STATE:  rd_val = {arms_left, rdg_cnt[10:0], state};
      default:           rd_hit = 1'b0;
    endcase
  end

  // One-cycle access phase: ready is raised for the cycle after setup.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_val : 32'h0;
    end
  end

endmodule // mtseq_top
`default_nettype wire

// [sim/mtseq_asserts.sv]
// Concurrent checks on the trigger sequencer ports, bound into the top module.
`timescale 1ns/1ps
`default_nettype none
module mtseq_asserts
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        reading_done,
  input wire logic        reading_start
);
  // Busy tracks one reading in flight, so a second start before its done is caught.
  logic busy;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy <= 1'b0;
    else if (reading_start)
      busy <= 1'b1;
    else if (reading_done)
      busy <= 1'b0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_ready_has_setup: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_data_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error read data not zero");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  a_start_one_pulse: assert property (reading_start |=> !reading_start) else $error("start longer than a pulse");
  a_start_after_done: assert property (reading_start |-> !busy) else $error("start before reading done");
endmodule // mtseq_asserts
bind mtseq_top mtseq_asserts mtseq_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .reading_done(reading_done), .reading_start(reading_start));
`default_nettype wire

// [sim/mtseq_engine_model.sv]
// Measurement engine model that finishes each reading a set number of cycles after its start.
`timescale 1ns/1ps
`default_nettype none
module mtseq_engine_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       reading_start,
  input  wire logic [7:0] lat,
  output var  logic       reading_done
);
  logic [7:0] cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt          <= 8'h00;
      reading_done <= 1'b0;
    end
    else
    begin
      reading_done <= (cnt == 8'h01);
      if (reading_start)
        cnt <= lat;
      else if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
    end
  end
endmodule // mtseq_engine_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking testbench of the trigger sequencer over APB.
`timescale 1ns/1ps
`default_nettype none
`include "mtseq_defs.vh"
module tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, lat = 8'h04;
  logic [31:0] pwdata = 32'h0, rd;
  logic        ext_trig = 1'b1, data_req = 1'b0, out_buf_empty = 1'b1, mem_off_or_empty = 1'b1, err;
  wire  [31:0] prdata;
  wire         pready, pslverr, reading_done, reading_start, autorange_en, irq;
  int          n_errors = 0, tests_run = 0, n_starts = 0, cyc = 0, base;
  time         t_prev = 0, t_last = 0;
  mtseq_top mtseq_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_trig(ext_trig),
    .data_req(data_req), .out_buf_empty(out_buf_empty), .mem_off_or_empty(mem_off_or_empty),
    .reading_done(reading_done), .reading_start(reading_start), .autorange_en(autorange_en), .irq(irq));
  mtseq_engine_model mtseq_engine_model_inst (.pclk(pclk), .presetn(presetn), .reading_start(reading_start),
    .lat(lat), .reading_done(reading_done));
  initial forever #4 pclk = ~pclk;
  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      stop_test;
    end
  end
  always @(posedge pclk)
  begin
    if (reading_start === 1'b1)
    begin
      n_starts <= n_starts + 1;
      t_prev   <= t_last;
      t_last   <= $time;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // The request stays put until pready is seen high, whatever the latency.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  task automatic pulse_ext;
    ext_trig <= 1'b0;
    wt(10);
    ext_trig <= 1'b1;
    wt(150);
  endtask
  task automatic pulse_req;
    data_req <= 1'b1;
    wt(3);
    data_req <= 1'b0;
    wt(100);
  endtask
  initial
  begin
    wt(10);
    presetn <= 1'b1;
    wt(2);
    check({31'h0, autorange_en}, 32'h1);
    chk(`MTSEQ_OFF_RPT, 32'hffff_ffff, 32'h1);
    chk(`MTSEQ_OFF_DELAY, 32'hffff_ffff, 32'h40);
    wr(`MTSEQ_OFF_MCONF, 32'h0002_0100);
    wt(2);
    chk(`MTSEQ_OFF_DELAY, 32'hffff_ffff, 32'h50);
    wr(`MTSEQ_OFF_DELAY, 32'ha);
    chk(`MTSEQ_OFF_DELAY, 32'hffff_ffff, 32'ha);
    wr(`MTSEQ_OFF_MCONF, 32'h0002_0000);
    wt(2);
    chk(`MTSEQ_OFF_DELAY, 32'hffff_ffff, 32'ha);
    wr(`MTSEQ_OFF_DELAY, 32'hffff_ffff);
    chk(`MTSEQ_OFF_DELAY, 32'hffff_ffff, 32'h40);
    apb(1'b0, 8'h24, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    wr(`MTSEQ_OFF_CTRL, 32'h2);
    wt(100);
    wr(`MTSEQ_OFF_RPT, 32'h3);
    base = n_starts;
    wr(`MTSEQ_OFF_CTRL, 32'h0002_0003);
    wt(400);
    check(32'(n_starts - base), 32'h6);
    chk(`MTSEQ_OFF_CTRL, 32'h7, 32'h2);
    chk(`MTSEQ_OFF_STATE, 32'h1f, 32'h1);
    wr(`MTSEQ_OFF_MASK, 32'h0);
    wt(2);
    check({31'h0, irq}, 32'h0);
    wr(`MTSEQ_OFF_MASK, 32'h1);
    wt(2);
    check({31'h0, irq}, 32'h1);
    wr(`MTSEQ_OFF_STATUS, 32'h1);
    wt(2);
    check({31'h0, irq}, 32'h0);
    // Arm repeat count set with an external arm must still arm only once per edge.
    wr(`MTSEQ_OFF_RPT, 32'h1);
    base = n_starts;
    wr(`MTSEQ_OFF_CTRL, 32'h0003_0001);
    pulse_ext;
    check(32'(n_starts - base), 32'h1);
    pulse_ext;
    check(32'(n_starts - base), 32'h2);
    // With automatic arming and an external trigger, each further edge starts a new group.
    wr(`MTSEQ_OFF_CTRL, 32'h8);
    pulse_ext;
    check(32'(n_starts - base), 32'h3);
    pulse_ext;
    check(32'(n_starts - base), 32'h4);
    // Trigger hold parks the sequencer so no group is under way when the controller event is chosen.
    wr(`MTSEQ_OFF_CTRL, 32'h12);
    wr(`MTSEQ_OFF_RPT, 32'h3);
    base = n_starts;
    wr(`MTSEQ_OFF_CTRL, 32'h20);
    data_req <= 1'b1;
    wt(3);
    data_req <= 1'b0;
    wt(2);
    data_req <= 1'b1;
    wt(300);
    check(32'(n_starts - base), 32'h3);
    data_req <= 1'b0;
    wr(`MTSEQ_OFF_CTRL, 32'h12);
    wr(`MTSEQ_OFF_SWEEP, 32'h0014_0002);
    wr(`MTSEQ_OFF_CTRL, 32'h0001_0143);
    wt(300);
    check(32'(t_last - t_prev), 32'd160);
    check({31'h0, autorange_en}, 32'h0);
    wr(`MTSEQ_OFF_TIMER, 32'h2);
    wr(`MTSEQ_OFF_RPT, 32'h2);
    wr(`MTSEQ_OFF_STATUS, 32'hf);
    wr(`MTSEQ_OFF_CTRL, 32'h0001_0143);
    wt(300);
    chk(`MTSEQ_OFF_STATUS, 32'h2, 32'h2);
    wr(`MTSEQ_OFF_MCONF, 32'h0002_0003);
    wr(`MTSEQ_OFF_STATUS, 32'hf);
    wr(`MTSEQ_OFF_SWEEP, 32'h0014_0002);
    chk(`MTSEQ_OFF_STATUS, 32'h4, 32'h4);
    wr(`MTSEQ_OFF_MCONF, 32'h0002_0000);
    wr(`MTSEQ_OFF_CTRL, 32'h2);
    wr(`MTSEQ_OFF_RPT, 32'h3);
    base = n_starts;
    wr(`MTSEQ_OFF_CTRL, 32'h100);
    wt(100);
    out_buf_empty <= 1'b0;
    pulse_req;
    out_buf_empty <= 1'b1;
    mem_off_or_empty <= 1'b0;
    pulse_req;
    check(32'(n_starts - base), 32'h0);
    mem_off_or_empty <= 1'b1;
    pulse_req;
    pulse_req;
    check(32'(n_starts - base), 32'h2);
    stop_test;
  end
endmodule // tb
`default_nettype wire
